// *** core/ats_sequencer.v ***
// Purpose: sequencer of a 10-bit successive-approximation converter
//          with software and compare-timer triggering
// Assumes: one clock, comparator and clear pin are asynchronous
// Notes:   mode registers arrive as plain write strobes with data
`timescale 1ns/1ns
`default_nettype none
`include "ats_defs.vh"

////////////////////////////////////////////////////////////////////////////
// What this block does
// (RL1) Four-buffer, inputs 0-3/8-11: results go to registers 0,1,2,3.
// (RL2) Four-buffer, inputs 4-7/12-15: results go to registers 4,5,6,7.
// (RL3) Scan from bank start to selected input; result k = input mod 8.
// (RL4) Software scan ends: one done pulse, then converting stops.
// (RL5) Writing enable one after a finished software scan starts anew.
// (RL6) Timer mode starts conversions only on compare channel matches.
// (RL7) One-shot timer: overflow holds zero, stops, no more triggers.
// (RL8) Stopped timer restarts on clear pin edge or run bit write.
// (RL9) Loop timer restarts from zero after overflow, triggers recur.
// (RL10) Optional: compare match clears the timer and restarts it.
// (RL11) Timer one-buffer: each trigger gives one conversion and one done.
// (RL12) One-shot timer without clear on match: one-buffer stops after one until timer restart.
// (RL13) Loop timer repeats conversions per trigger while enable is set.
// (RL14) Timer four-buffer: one conversion per trigger, done after fourth.
// (RL15) Timer scan: done after range; later trigger rescans from first.
// (RL16) A mode register write aborts the conversion, nothing stored.
// (RL17) Trigger source from bits 7..3 of the second mode register.
// (RL18) Ten bits resolved by comparison; stored only when all done.
// (RL19) Clearing enable mid-conversion stops it, results unchanged.
// (RL20) Results are read-only and hold until a later completed store.
module ats_sequencer (
	// clock and reset
	input  wire        CLK_I,
	input  wire        NRST_I,
	// mode register writes
	input  wire        MODE0_WR_I,
	input  wire [7:0]  MODE0_DATA_I,
	input  wire        MODE1_WR_I,
	input  wire [7:0]  MODE1_DATA_I,
	// trigger timer control write
	input  wire        TMR_WR_I,
	input  wire        TMR_ONE_SHOT_I,
	input  wire        TMR_RUN_I,
	input  wire        TMR_CLR_ON_MATCH_I,
	input  wire [23:0] TMR_CMP_I,
	input  wire        TIMER_CLEAR_PIN_I,
	// analog side
	input  wire        COMP_I,
	output wire [3:0]  MUX_SEL_O,
	output wire [9:0]  DAC_CODE_O,
	// status and results
	output wire        CONV_DONE_IRQ_O,
	output wire        CE_O,
	output wire        BUSY_O,
	output wire        STANDBY_O,
	output wire        COMPARE_MATCH_TRIGGER_O,
	output wire        TIMER_RUN_O,
	output wire [23:0] TIMER_COUNT_O,
	output wire [79:0] RESULT_O
);

	localparam S_IDLE = 3'b001;
	localparam S_STBY = 3'b010;
	localparam S_CONV = 3'b100;
	// derived count is 32 bits wide; keep only the tick counter's width
	localparam [31:0] TICK_LAST_W = `ATS_BIT_CYC - 1;
	localparam [3:0]  TICK_LAST   = TICK_LAST_W[3:0];

	reg  [2:0]  state_reg;
	reg         ce_reg;
	reg  [7:0]  mode0_reg;
	reg  [7:0]  mode1_reg;
	reg  [3:0]  chan_reg;
	reg  [1:0]  cnt4_reg;
	reg  [3:0]  bit_reg;
	reg  [3:0]  tick_reg;
	reg  [9:0]  dac_reg;
	reg         irq_reg;
	reg  [23:0] tcnt_reg;
	reg  [23:0] tcmp_reg;
	reg         trun_reg;
	reg         tost_reg;
	reg         tclr_reg;
	reg         trig_reg;
	reg  [2:0]  clr_sync_reg;
	reg         clr_lvl_reg;
	reg  [2:0]  comp_sync_reg;
	reg         comp_lvl_reg;
	reg  [9:0]  result_mem [0:7];

	wire        mode_wr   = MODE0_WR_I | MODE1_WR_I;
	wire [3:0]  sel_ch    = mode0_reg[`ATS_M0_CH_MSB:`ATS_M0_CH_LSB];
	wire        is_select = mode0_reg[`ATS_M0_SELECT_BIT];
	wire        is_four   = is_select & mode0_reg[`ATS_M0_FOUR_BIT];
	wire [4:0]  trg_src   = mode1_reg[`ATS_M1_TRG_MSB:`ATS_M1_TRG_LSB];
	wire        src_soft  = (trg_src == `ATS_TRG_SOFT);  // RL17
	wire        src_timer = (trg_src == `ATS_TRG_TIMER); // RL17
	wire        tm_trig   = src_timer & trig_reg;        // RL6
	wire [3:0]  first_ch  = is_select ? sel_ch : {sel_ch[3], 3'h0};
	wire [9:0]  bit_mask  = 10'h001 << bit_reg;
	wire [9:0]  low_mask  = bit_mask >> 1;
	// keep trial bit when input is above the trial level
	wire [9:0]  decided   = comp_lvl_reg ? dac_reg : (dac_reg & ~bit_mask);
	wire        step_end  = state_reg[2] & (tick_reg == TICK_LAST);
	wire        restart   = state_reg[2] & tm_trig;
	wire        store_now = step_end & (bit_reg == 4'h0) & ~restart &
		~mode_wr;                                        // RL18 RL16
	wire [2:0]  store_idx = is_four ? {sel_ch[2], cnt4_reg} : chan_reg[2:0];
	wire [7:0]  store_sel = 8'h01 << store_idx;      // one-hot target
	wire        clr_edge  = (clr_sync_reg[1] == clr_sync_reg[2]) &
		clr_sync_reg[2] & ~clr_lvl_reg;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers; a level counts once stages two and three agree
	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			clr_sync_reg  <= 3'h0;
			clr_lvl_reg   <= 1'b0;
			comp_sync_reg <= 3'h0;
			comp_lvl_reg  <= 1'b0;
		end else begin
			clr_sync_reg  <= {clr_sync_reg[1:0], TIMER_CLEAR_PIN_I};
			comp_sync_reg <= {comp_sync_reg[1:0], COMP_I};
			if (clr_sync_reg[1] == clr_sync_reg[2])
				clr_lvl_reg <= clr_sync_reg[2];
			if (comp_sync_reg[1] == comp_sync_reg[2])
				comp_lvl_reg <= comp_sync_reg[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// 24-bit trigger timer with compare channel
	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			tcnt_reg <= `ATS_TMR_ZERO;
			tcmp_reg <= `ATS_TMR_MAX;
			trun_reg <= 1'b0;
			tost_reg <= 1'b0;
			tclr_reg <= 1'b0;
			trig_reg <= 1'b0;
		end else begin
			trig_reg <= 1'b0;
			if (TMR_WR_I) begin
				tost_reg <= TMR_ONE_SHOT_I;
				tclr_reg <= TMR_CLR_ON_MATCH_I;
				tcmp_reg <= TMR_CMP_I;
				trun_reg <= TMR_RUN_I;                   // RL8
			end
			if (clr_edge) begin
				tcnt_reg <= `ATS_TMR_ZERO;               // RL8
				trun_reg <= 1'b1;
			end else if (trun_reg) begin
				// a stopped timer makes no match, so no trigger
				if (tcnt_reg == tcmp_reg)
					trig_reg <= 1'b1;                    // RL6
				if (tcnt_reg == tcmp_reg && tclr_reg) begin
					tcnt_reg <= `ATS_TMR_ZERO;           // RL10
				end else if (tcnt_reg == `ATS_TMR_MAX) begin
					tcnt_reg <= `ATS_TMR_ZERO;           // RL9
					if (tost_reg && !TMR_WR_I)
						trun_reg <= 1'b0;                // RL7
				end else begin
					tcnt_reg <= tcnt_reg + 24'h000001;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: idle, trigger standby, converting
	always @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			state_reg <= S_IDLE;
			ce_reg    <= 1'b0;
			mode0_reg <= `ATS_M0_RESET;
			mode1_reg <= `ATS_M1_RESET;
			chan_reg  <= 4'h0;
			cnt4_reg  <= 2'h0;
			bit_reg   <= `ATS_BIT_TOP;
			tick_reg  <= 4'h0;
			dac_reg   <= `ATS_DAC_FIRST;
			irq_reg   <= 1'b0;
		end else begin
			irq_reg <= 1'b0;
			if (mode_wr) begin
				// any rewrite aborts; write wins over a hardware enable clear
				if (MODE0_WR_I) begin
					mode0_reg <= MODE0_DATA_I;
					ce_reg    <= MODE0_DATA_I[`ATS_M0_CE_BIT]; // RL5 RL19
				end
				if (MODE1_WR_I)
					mode1_reg <= MODE1_DATA_I;
				cnt4_reg  <= 2'h0;
				state_reg <= S_IDLE;                     // RL16 RL19
			end else begin
				case (state_reg)
				S_IDLE: begin
					if (ce_reg && src_soft) begin
						chan_reg  <= first_ch;           // RL5
						cnt4_reg  <= 2'h0;
						tick_reg  <= 4'h0;
						bit_reg   <= `ATS_BIT_TOP;
						dac_reg   <= `ATS_DAC_FIRST;
						state_reg <= S_CONV;
					end else if (ce_reg && src_timer) begin
						state_reg <= S_STBY;
					end
				end
				S_STBY: begin
					if (tm_trig) begin
						chan_reg  <= first_ch;           // RL15 RL13
						tick_reg  <= 4'h0;
						bit_reg   <= `ATS_BIT_TOP;
						dac_reg   <= `ATS_DAC_FIRST;
						state_reg <= S_CONV;
					end
				end
				S_CONV: begin
					if (restart) begin
						// early trigger: drop this conversion, convert again
						tick_reg <= 4'h0;
						bit_reg  <= `ATS_BIT_TOP;
						dac_reg  <= `ATS_DAC_FIRST;
					end else if (!step_end) begin
						tick_reg <= tick_reg + 4'h1;
					end else if (bit_reg != 4'h0) begin
						tick_reg <= 4'h0;
						bit_reg  <= bit_reg - 4'h1;
						dac_reg  <= decided | low_mask;  // RL18
					end else begin
						tick_reg <= 4'h0;
						bit_reg  <= `ATS_BIT_TOP;
						dac_reg  <= `ATS_DAC_FIRST;
						if (!is_select && chan_reg != sel_ch) begin
							chan_reg <= chan_reg + 4'h1; // RL3
						end else if (is_four && cnt4_reg != 2'h3) begin
							cnt4_reg <= cnt4_reg + 2'h1; // RL1 RL2
							if (!src_soft)
								state_reg <= S_STBY;     // RL14
						end else begin
							cnt4_reg <= 2'h0;
							irq_reg  <= 1'b1;            // RL4 RL11 RL14 RL15
							if (src_soft) begin
								ce_reg    <= 1'b0;       // RL4
								state_reg <= S_IDLE;
							end else begin
								state_reg <= S_STBY;     // RL12 RL13
							end
						end
					end
				end
				default: state_reg <= S_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// result registers, written only by a completed conversion
	genvar gi;
	generate
		for (gi = 0; gi < `ATS_RES_COUNT; gi = gi + 1) begin : g_res
			always @(posedge CLK_I or negedge NRST_I) begin
				if (!NRST_I)
					result_mem[gi] <= `ATS_RES_RESET;
				else if (store_now && store_sel[gi])
					result_mem[gi] <= decided;           // RL20 RL1 RL2 RL3
			end
			assign RESULT_O[gi*10 +: 10] = result_mem[gi];
		end
	endgenerate

	// outputs straight from flip-flops
	assign MUX_SEL_O               = chan_reg;
	assign DAC_CODE_O              = dac_reg;
	assign CONV_DONE_IRQ_O         = irq_reg;
	assign CE_O                    = ce_reg;
	assign BUSY_O                  = state_reg[2];
	assign STANDBY_O               = state_reg[1];
	assign COMPARE_MATCH_TRIGGER_O = trig_reg;
	assign TIMER_RUN_O             = trun_reg;
	assign TIMER_COUNT_O           = tcnt_reg;

endmodule
`default_nettype wire

// *** core/ats_defs.vh ***
// Purpose: constants of the converter trigger sequencer
// Assumes: 250 MHz core clock
// Notes:   mode field layout and timing are shared by design and bench
`ifndef ATS_DEFS_VH
`define ATS_DEFS_VH

// first mode register fields
`define ATS_M0_CE_BIT      7
`define ATS_M0_FOUR_BIT    5
`define ATS_M0_SELECT_BIT  4
`define ATS_M0_CH_MSB      3
`define ATS_M0_CH_LSB      0
`define ATS_M0_RESET       8'h00

// second mode register: trigger source in bits 7..3
`define ATS_M1_TRG_MSB     7
`define ATS_M1_TRG_LSB     3
`define ATS_M1_RESET       8'h00
`define ATS_TRG_SOFT       5'h00
`define ATS_TRG_TIMER      5'h02
`define ATS_TRG_EXT        5'h04

// converter geometry
`define ATS_RES_BITS       10
`define ATS_RES_COUNT      8
`define ATS_DAC_FIRST      10'h200
`define ATS_BIT_TOP        4'h9
`define ATS_RES_RESET      10'h000

// trigger timer
`define ATS_TMR_BITS       24
`define ATS_TMR_MAX        24'hffffff
`define ATS_TMR_ZERO       24'h000000

// time for one comparison step, and the cycle count derived from it
`define ATS_CLK_NS         4
`define ATS_BIT_NS         32
`define ATS_BIT_CYC        ((`ATS_BIT_NS + `ATS_CLK_NS - 1) / `ATS_CLK_NS)

`endif

// *** testbench/ats_analog_model.sv ***
// Purpose: analog input mux and comparator on the far side
// Assumes: input n sits at code {n, 2a} plus half a step
// Notes:   the half step keeps every comparator decision clear
`timescale 1ns/1ns
`default_nettype none
module ats_analog_model (
	// converter side
	input  wire logic [3:0] mux_sel_i,
	input  wire logic [9:0] dac_code_i,
	// comparator decision
	output logic            comp_o
);
	// high while the selected input is above the trial level
	assign comp_o = {mux_sel_i, 6'h2a, 1'b1} > {dac_code_i, 1'b0};
endmodule
`default_nettype wire

// *** testbench/ats_seq_props.sv ***
// Purpose: port timing checks of the trigger sequencer
// Assumes: one clock, reset low and asynchronous
// Notes:   trigger source is shadowed from second mode writes
`timescale 1ns/1ns
`default_nettype none
`include "ats_defs.vh"
module ats_seq_props (
	// clock, reset and writes
	input wire logic        CLK_I,
	input wire logic        NRST_I,
	input wire logic        MODE0_WR_I,
	input wire logic        MODE1_WR_I,
	input wire logic [7:0]  MODE1_DATA_I,
	input wire logic        TIMER_CLEAR_PIN_I,
	// watched outputs
	input wire logic        CONV_DONE_IRQ_O,
	input wire logic        CE_O,
	input wire logic        BUSY_O,
	input wire logic        STANDBY_O,
	input wire logic        COMPARE_MATCH_TRIGGER_O,
	input wire logic        TIMER_RUN_O,
	input wire logic [9:0]  DAC_CODE_O,
	input wire logic [79:0] RESULT_O
);
	logic [4:0] src_reg;
	// shadow of the trigger source field
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			src_reg <= 5'h00;
		else if (MODE1_WR_I)
			src_reg <= MODE1_DATA_I[7:3];
	end
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);
	sequence s_idle;
		!BUSY_O && !STANDBY_O;
	endsequence
	sequence s_wr;
		MODE0_WR_I || MODE1_WR_I;
	endsequence
	property p_abort;
		s_wr |=> ##[0:1] s_idle;
	endproperty
	property p_nostore;
		s_wr |=> $stable(RESULT_O) [*2];
	endproperty
	property p_start;
		$rose(BUSY_O) |-> CE_O && DAC_CODE_O == `ATS_DAC_FIRST;
	endproperty
	property p_timer;
		src_reg == `ATS_TRG_TIMER && $rose(BUSY_O) |->
			$past(COMPARE_MATCH_TRIGGER_O) ||
			$past(COMPARE_MATCH_TRIGGER_O, 2);
	endproperty
	property p_done;
		CONV_DONE_IRQ_O |-> $past(BUSY_O, 2) ##1 !CONV_DONE_IRQ_O;
	endproperty
	property p_soft_end;
		src_reg == `ATS_TRG_SOFT && CONV_DONE_IRQ_O |->
			##[0:2] (!CE_O && !BUSY_O);
	endproperty
	property p_match;
		COMPARE_MATCH_TRIGGER_O |=> !COMPARE_MATCH_TRIGGER_O;
	endproperty
	property p_stopped;
		!TIMER_RUN_O [*3] |-> !COMPARE_MATCH_TRIGGER_O;
	endproperty
	property p_clear;
		$rose(TIMER_CLEAR_PIN_I) |-> ##[1:8] TIMER_RUN_O;
	endproperty
	property p_result;
		$changed(RESULT_O) |-> $past(BUSY_O);
	endproperty
	a_abort: assert property (p_abort)
		else $error("mode write left converter busy");
	a_nostore: assert property (p_nostore)
		else $error("result stored after mode write");
	a_start: assert property (p_start)
		else $error("bad conversion start");
	a_timer: assert property (p_timer)
		else $error("timer start without match");
	a_done: assert property (p_done)
		else $error("bad done pulse");
	a_soft_end: assert property (p_soft_end)
		else $error("soft scan did not stop");
	a_match: assert property (p_match)
		else $error("match pulse too long");
	a_stopped: assert property (p_stopped)
		else $error("match from stopped timer");
	a_clear: assert property (p_clear)
		else $error("clear pin did not start timer");
	a_result: assert property (p_result)
		else $error("result changed while idle");
endmodule
//////////////////////////////////////////////////////////////////////////////
bind ats_sequencer ats_seq_props u_props (
	.CLK_I(CLK_I), .NRST_I(NRST_I), .MODE0_WR_I(MODE0_WR_I),
	.MODE1_WR_I(MODE1_WR_I), .MODE1_DATA_I(MODE1_DATA_I),
	.TIMER_CLEAR_PIN_I(TIMER_CLEAR_PIN_I),
	.CONV_DONE_IRQ_O(CONV_DONE_IRQ_O), .CE_O(CE_O), .BUSY_O(BUSY_O),
	.STANDBY_O(STANDBY_O), .TIMER_RUN_O(TIMER_RUN_O),
	.COMPARE_MATCH_TRIGGER_O(COMPARE_MATCH_TRIGGER_O),
	.DAC_CODE_O(DAC_CODE_O), .RESULT_O(RESULT_O));
`default_nettype wire

// *** testbench/ats_sequencer_bench.sv ***
// Purpose: directed tests of the converter trigger sequencer
// Assumes: inputs change on the falling clock edge
// Notes:   timer overflow takes too long and is left to assertions
`timescale 1ns/1ns
`default_nettype none
module ats_sequencer_bench;
	logic        clk = 0, nrst_n = 0, m0_wr = 0, m1_wr = 0;
	logic [7:0]  m0_d = 8'h00, m1_d = 8'h00;
	logic        t_wr = 0, t_run = 0, clr_pin = 0;
	logic        t_ost = 0, t_com = 1;
	logic [23:0] t_cmp = 24'hffffff;
	wire logic   comp, irq, ce, busy, trg, trun;
	wire logic [3:0]  mux;
	wire logic [9:0]  dac;
	wire logic [23:0] tcnt;
	wire logic [79:0] res_o;
	int n_fail = 0, compares = 0, ndone = 0, ntrg = 0, k, d;
	ats_sequencer u_dut (.CLK_I(clk), .NRST_I(nrst_n),
		.MODE0_WR_I(m0_wr), .MODE0_DATA_I(m0_d), .MODE1_WR_I(m1_wr),
		.MODE1_DATA_I(m1_d), .TMR_WR_I(t_wr), .TMR_ONE_SHOT_I(t_ost),
		.TMR_RUN_I(t_run), .TMR_CLR_ON_MATCH_I(t_com), .TMR_CMP_I(t_cmp),
		.TIMER_CLEAR_PIN_I(clr_pin), .COMP_I(comp), .MUX_SEL_O(mux),
		.DAC_CODE_O(dac), .CONV_DONE_IRQ_O(irq), .CE_O(ce),
		.BUSY_O(busy), .STANDBY_O(), .COMPARE_MATCH_TRIGGER_O(trg),
		.TIMER_RUN_O(trun), .TIMER_COUNT_O(tcnt), .RESULT_O(res_o));
	ats_analog_model u_ana (.mux_sel_i(mux), .dac_code_i(dac),
		.comp_o(comp));
	always #2 clk = ~clk;
	// event counters; a one-cycle pulse is read at the edge that ends it
	always @(posedge clk) begin
		if (irq === 1'b1) ndone++;
		if (trg === 1'b1) ntrg++;
	end
	task chk(input string nm, input logic [9:0] e, g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task rchk(input int r, input logic [3:0] ch);
		chk("result", {ch, 6'h2a}, res_o[10*r +: 10]);
	endtask
	// one-cycle write strobe to a mode register
	task wm(input logic sel, input logic [7:0] v);
		@(negedge clk);
		if (sel) begin m1_wr = 1; m1_d = v; end
		else begin m0_wr = 1; m0_d = v; end
		@(negedge clk);
		m0_wr = 0;
		m1_wr = 0;
	endtask
	// one-cycle load of all timer controls
	task tmr(input logic ost, com, run, input logic [23:0] cmp);
		@(negedge clk);
		t_wr = 1; t_ost = ost; t_com = com;
		t_run = run; t_cmp = cmp;
		@(negedge clk);
		t_wr = 0;
	endtask
	// bounded wait for the next done pulse
	task wdone;
		int i, d0;
		d0 = ndone;
		for (i = 0; i < 3000 && ndone == d0; i++) @(negedge clk);
		chk("done seen", 1, 10'(ndone != d0));
	endtask
	task test_done;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	//////////////////////////////////////////////////////////////////////
	initial begin
		#240000;
		n_fail++;
		test_done;
	end
	initial begin
		repeat (20) @(negedge clk);
		nrst_n = 1;
		wm(1, 8'h00);
		wm(0, 8'h8a);
		wdone;
		for (k = 0; k < 3; k++) rchk(k, 4'(8 + k));
		repeat (300) @(negedge clk);
		chk("done count", 1, 10'(ndone));
		chk("enable", 0, 10'(ce));
		wm(0, 8'hb5);
		wdone;
		for (k = 4; k < 8; k++) rchk(k, 4'h5);
		wm(0, 8'hb2);
		wdone;
		for (k = 0; k < 4; k++) rchk(k, 4'h2);
		wm(0, 8'h91);
		repeat (40) @(negedge clk);
		wm(0, 8'h11);
		repeat (200) @(negedge clk);
		rchk(1, 4'h2);
		wm(0, 8'h91);
		repeat (40) @(negedge clk);
		wm(1, 8'h00);
		rchk(1, 4'h2);
		wdone;
		rchk(1, 4'h1);
		// loop timer, clear on match, period near 400 cycles
		wm(1, 8'h10);
		tmr(0, 1, 1, 24'd400);
		wm(0, 8'h93);
		d = ndone;
		repeat (1800) @(negedge clk);
		chk("loop dones", 4, 10'(ndone - d));
		rchk(3, 4'h3);
		wm(0, 8'h13);
		d = ndone;
		repeat (900) @(negedge clk);
		chk("stopped dones", 0, 10'(ndone - d));
		// stop; one-shot only halts at overflow, which clear on match avoids
		tmr(1, 1, 0, 24'd400);
		wm(0, 8'hbc);
		repeat (5) @(negedge clk);
		chk("timer run", 0, 10'(trun));
		d = ntrg;
		clr_pin = 1;
		repeat (10) @(negedge clk);
		chk("timer run", 1, 10'(trun));
		// edge taken after three stages, count zeroed, then six increments
		chk("timer count", 6, 10'(tcnt));
		wdone;
		chk("triggers", 4, 10'(ntrg - d));
		for (k = 4; k < 8; k++) rchk(k, 4'hc);
		wm(0, 8'h82);
		wdone;
		wdone;
		for (k = 0; k < 3; k++) rchk(k, 4'(k));
		// external source idles; timer without clear on match fires once
		wm(1, 8'h20);
		clr_pin = 0;
		tmr(0, 0, 0, 24'd20);
		repeat (8) @(negedge clk);
		d = ntrg;
		k = ndone;
		clr_pin = 1;
		repeat (300) @(negedge clk);
		chk("single match", 1, 10'(ntrg - d));
		chk("ext dones", 0, 10'(ndone - k));
		chk("busy", 0, 10'(busy));
		test_done;
	end
endmodule
`default_nettype wire
